/* File: src/dtr_map.svh */
`ifndef DTR_MAP_SVH
`define DTR_MAP_SVH

// ==========================================================
// Port addresses
`define DTR_ADDR_TEST_OUTPUT_SELECT      16'h9872
`define DTR_ADDR_DELAY     16'hA072
`define DTR_ADDR_TEST_EN   16'hA872
`define DTR_ADDR_STATUS    16'hDC72

// ==========================================================
// Diagnostic register fields
`define DTR_TEST_OUTPUT_SELECT_SEL_MSB   5
`define DTR_TEST_OUTPUT_SELECT_STATE_BIT 6
`define DTR_SEL_NORMAL     6'h00
`define DTR_SEL_SPK_OFF    6'h01
`define DTR_TEST_OUTPUT_SELECT_SEL_RST   6'h00

// ==========================================================
// Delay line register fields
`define DTR_DLY_LOCK_BIT   7
`define DTR_DLY_FREEZE_BIT 6
`define DTR_DLY_CNT_MSB    5
`define DTR_DLY_CNT_INIT   6'h20

// ==========================================================
// Test enable register fields
`define DTR_TE_RW_MSB      9
`define DTR_TE_RW_RST      10'h000
// Arbitrary neutral stepping code
`define DTR_SEC_REV        4'h6

// ==========================================================
// Strength thresholds on the delay count and reset strength
`define DTR_TH_MID         6'h18
`define DTR_TH_FULL        6'h30
`define DTR_STR_RST        2'h3

`endif

/* File: src/dtr_pkg.sv */
`include "dtr_map.svh"

package dtr_pkg;

  // I/O port request from the host side decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } dtr_io_s;

  // Writable test enable bits 09-00
  typedef struct packed {
    logic retrace_activity_unmask;
    logic delay_line_test;
    logic cpu_type_test_enable;
    logic dma_regfile_test_a;
    logic dma_regfile_test_b;
    logic ems_map_test_a;
    logic ems_map_test_b;
    logic pulldown_enable;
    logic first_access_page_disable;
    logic level_irq_enable;
  } dtr_test_en_s;

  // Calibrator phase
  typedef enum logic {
    DTR_CAL_SEEK,
    DTR_CAL_TRACK
  } dtr_cal_e;

  // Count to strength as {strength_mid, slow}; 01 never produced
  function automatic logic [1:0] dtr_strength(input logic [5:0] cnt);
    if (cnt < `DTR_TH_MID)
      return 2'h0;
    else if (cnt < `DTR_TH_FULL)
      return 2'h2;
    else
      return 2'h3;
  endfunction

endpackage

/* File: src/dtr_sync3.sv */
`timescale 1ns/1ps

module dtr_sync3
  import dtr_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // Three stages; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst)
      dout <= '0;
    else
      dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
  end

endmodule

/* File: src/dtr_delay_cal.sv */
`timescale 1ns/1ps
`include "dtr_map.svh"

module dtr_delay_cal
  import dtr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       refresh,
  input  wire logic       too_short,
  input  wire logic       freeze,
  input  wire logic       lock,
  input  wire logic       load,
  input  wire logic [5:0] load_val,
  output logic      [5:0] count,
  output logic      [1:0] strength,
  output logic            cal_done,
  output logic            step_up
);

  dtr_cal_e   phase;
  logic [5:0] prev_count;

  // ==========================================================
  // Delay counter: one element per refresh unless frozen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count   <= `DTR_DLY_CNT_INIT;
      step_up <= 1'b0;
    end else if (freeze) begin
      if (load)
        count <= load_val;
    end else if (refresh) begin
      step_up <= too_short;
      if (too_short && count != 6'h3F)
        count <= count + 6'h01;
      else if (!too_short && count != 6'h00)
        count <= count - 6'h01;
    end
  end

  // First reversal of direction ends initial calibration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase    <= DTR_CAL_SEEK;
      cal_done <= 1'b0;
    end else begin
      case (phase)
        DTR_CAL_SEEK: begin
          if (refresh && !freeze && count != `DTR_DLY_CNT_INIT && too_short != step_up) begin
            phase    <= DTR_CAL_TRACK;
            cal_done <= 1'b1;
          end
        end
        DTR_CAL_TRACK: cal_done <= 1'b1;
        default:       phase <= DTR_CAL_SEEK;
      endcase
    end
  end

  // Strength recomputed on a count change unless locked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strength   <= `DTR_STR_RST;
      prev_count <= `DTR_DLY_CNT_INIT;
    end else begin
      prev_count <= count;
      if (!lock && count != prev_count)
        strength <= dtr_strength(count);
    end
  end

  // ==========================================================
  // Checks
  property p_freeze_holds;
    @(posedge clk_sys) disable iff (rst)
      (freeze && !load) |=> $stable(count);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("count moved while frozen");

  property p_step_one;
    @(posedge clk_sys) disable iff (rst)
      (!freeze && refresh) |=> (count - $past(count) == 6'h01 || $past(count) - count == 6'h01
                                || $stable(count));
  endproperty
  a_step_one: assert property (p_step_one) else $error("step not one element");

  property p_lock_holds;
    @(posedge clk_sys) disable iff (rst)
      lock |=> $stable(strength);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("strength moved while locked");

endmodule

/* File: src/dtr_regs.sv */
`timescale 1ns/1ps
`include "dtr_map.svh"


module dtr_regs
  import dtr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire dtr_io_s     io_req,
  output logic      [15:0] io_rdata,
  input  wire logic [63:0] test_output_select_sources,
  input  wire logic        refresh_cycle,
  input  wire logic        delay_too_short,
  input  wire logic [1:0]  ems_selftest_in,
  input  wire logic [5:0]  selftest_in,
  input  wire logic        line9_request_flag,
  input  wire logic        line9_service_flag,
  input  wire logic        cpu_power_down,
  input  wire logic        full_power_down,
  input  wire logic        irq_edge_level_sel,
  output logic             speaker_enable,
  output logic             test_output_select_output_enable,
  output logic             activity_line9_request,
  output logic             activity_line9_service,
  output logic             pulldown_on,
  output logic             first_access_page_disable,
  output logic             irq_level_mode,
  output logic [5:0]       factory_test_enables,
  output logic [1:0]       buffer_strength
);

  // ==========================================================
  // Storage
  logic [5:0]   test_output_select;
  logic         strength_lock;
  logic         delay_freeze;
  logic [7:0]   delay_upper;
  dtr_test_en_s test_en;

  // Synchronised pins
  logic [63:0]  test_output_select_sync;
  logic [7:0]   node_sync;
  logic [1:0]   ems_selftest;
  logic [5:0]   selftest_nodes;
  logic         too_short_sync;

  // Calibrator
  logic [5:0]   delay_count;
  logic [1:0]   strength;
  logic         cal_done;
  logic         step_up;
  logic         delay_load;

  // Read mux
  logic [15:0]  next_rdata;
  logic         test_signal_state;
  logic [6:0]   delay_node_taps;

  // Write strobes
  logic         wr_test_output_select;
  logic         wr_delay;
  logic         wr_test;

  assign wr_test_output_select  = io_req.wr && io_req.addr == `DTR_ADDR_TEST_OUTPUT_SELECT;
  assign wr_delay = io_req.wr && io_req.addr == `DTR_ADDR_DELAY;
  assign wr_test  = io_req.wr && io_req.addr == `DTR_ADDR_TEST_EN;

  // ==========================================================
  // Pin synchronisers
  dtr_sync3 #(
    .W (64)
  ) u_sync_test_output_select (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (test_output_select_sources),
    .dout    (test_output_select_sync)
  );

  dtr_sync3 #(
    .W (9)
  ) u_sync_nodes (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({delay_too_short, ems_selftest_in, selftest_in}),
    .dout    ({too_short_sync, node_sync})
  );

  assign ems_selftest   = node_sync[7:6];
  assign selftest_nodes = node_sync[5:0];

  // ==========================================================
  // Diagnostic select
  always_ff @(posedge clk_sys) begin
    if (rst)
      test_output_select <= `DTR_TEST_OUTPUT_SELECT_SEL_RST;
    else if (wr_test_output_select)
      test_output_select <= io_req.wdata[`DTR_TEST_OUTPUT_SELECT_SEL_MSB:0];
  end

  // Live state of the selected source
  assign test_signal_state = test_output_select_sync[test_output_select];

  // Speaker silenced only by code 1; reserved codes drive observation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      speaker_enable     <= 1'b1;
      test_output_select_output_enable <= 1'b0;
    end else begin
      speaker_enable     <= test_output_select != `DTR_SEL_SPK_OFF;
      test_output_select_output_enable <= test_output_select != `DTR_SEL_NORMAL
                            && test_output_select != `DTR_SEL_SPK_OFF;
    end
  end

  // ==========================================================
  // Delay line control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strength_lock <= 1'b0;
      delay_freeze  <= 1'b0;
    end else if (wr_delay) begin
      strength_lock <= io_req.wdata[`DTR_DLY_LOCK_BIT];
      delay_freeze  <= io_req.wdata[`DTR_DLY_FREEZE_BIT];
    end
  end

  // Upper byte is plain storage without a reset value
  always_ff @(posedge clk_sys) begin
    if (wr_delay)
      delay_upper <= io_req.wdata[15:8];
  end

  // Counter load honoured only when freeze was already set
  assign delay_load = wr_delay && delay_freeze;

  dtr_delay_cal u_cal (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .refresh   (refresh_cycle),
    .too_short (too_short_sync),
    .freeze    (delay_freeze),
    .lock      (strength_lock),
    .load      (delay_load),
    .load_val  (io_req.wdata[`DTR_DLY_CNT_MSB:0]),
    .count     (delay_count),
    .strength  (strength),
    .cal_done  (cal_done),
    .step_up   (step_up)
  );

  // Internal tap view: count plus tuning direction
  assign delay_node_taps = {delay_count, step_up};

  // ==========================================================
  // Test enable register; top six bits never stored
  always_ff @(posedge clk_sys) begin
    if (rst)
      test_en <= `DTR_TE_RW_RST;
    else if (wr_test)
      test_en <= io_req.wdata[`DTR_TE_RW_MSB:0];
  end

  // ==========================================================
  // Controls for neighbouring blocks, registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      activity_line9_request    <= 1'b0;
      activity_line9_service    <= 1'b0;
      pulldown_on               <= 1'b0;
      first_access_page_disable <= 1'b0;
      irq_level_mode            <= 1'b0;
      factory_test_enables      <= 6'h00;
      buffer_strength           <= `DTR_STR_RST;
    end else begin
      activity_line9_request    <= line9_request_flag && test_en.retrace_activity_unmask;
      activity_line9_service    <= line9_service_flag && test_en.retrace_activity_unmask;
      pulldown_on               <= test_en.pulldown_enable
                                   && (cpu_power_down || full_power_down);
      first_access_page_disable <= test_en.first_access_page_disable;
      irq_level_mode            <= test_en.level_irq_enable && irq_edge_level_sel;
      factory_test_enables      <= {test_en.delay_line_test,
                                    test_en.cpu_type_test_enable,
                                    test_en.dma_regfile_test_a,
                                    test_en.dma_regfile_test_b,
                                    test_en.ems_map_test_a,
                                    test_en.ems_map_test_b};
      buffer_strength           <= strength;
    end
  end

  // ==========================================================
  // Read path; unmapped ports read as zero
  always_comb begin
    next_rdata = 16'h0000;
    case (io_req.addr)
      `DTR_ADDR_TEST_OUTPUT_SELECT:
        next_rdata = {9'h000, test_signal_state, test_output_select};
      `DTR_ADDR_DELAY:
        next_rdata = {delay_upper, strength_lock, delay_freeze, delay_count};
      `DTR_ADDR_TEST_EN:
        next_rdata = {`DTR_SEC_REV, ems_selftest, test_en};
      `DTR_ADDR_STATUS:
        next_rdata = {cal_done, strength, delay_node_taps, selftest_nodes};
      default:
        next_rdata = 16'h0000;
    endcase
  end

  // Read data captured on the strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (rst)
      io_rdata <= 16'h0000;
    else if (io_req.rd)
      io_rdata <= next_rdata;
  end

  // ==========================================================
  // Checks
  property p_ds_live;
    @(posedge clk_sys) disable iff (rst)
      (io_req.rd && io_req.addr == `DTR_ADDR_TEST_OUTPUT_SELECT)
        |=> io_rdata[`DTR_TEST_OUTPUT_SELECT_STATE_BIT] == $past(test_output_select_sync[test_output_select]);
  endproperty
  a_ds_live: assert property (p_ds_live) else $error("test_output_select state bit wrong");

  property p_speaker_off;
    @(posedge clk_sys) disable iff (rst)
      (test_output_select == `DTR_SEL_SPK_OFF) |=> !speaker_enable && !test_output_select_output_enable;
  endproperty
  a_speaker_off: assert property (p_speaker_off) else $error("speaker not silenced");

  property p_load_ignored;
    @(posedge clk_sys) disable iff (rst)
      (wr_delay && !delay_freeze && !refresh_cycle) |=> $stable(delay_count);
  endproperty
  a_load_ignored: assert property (p_load_ignored) else $error("count written while not frozen");

  property p_te_top_ro;
    @(posedge clk_sys) disable iff (rst)
      (io_req.rd && io_req.addr == `DTR_ADDR_TEST_EN) |=> io_rdata[15:12] == `DTR_SEC_REV;
  endproperty
  a_te_top_ro: assert property (p_te_top_ro) else $error("stepping code wrong");

  property p_te_write;
    @(posedge clk_sys) disable iff (rst)
      wr_test |=> test_en == $past(io_req.wdata[9:0]);
  endproperty
  a_te_write: assert property (p_te_write) else $error("test enable not stored");

  property p_unmask;
    @(posedge clk_sys) disable iff (rst)
      !test_en.retrace_activity_unmask ##1 !test_en.retrace_activity_unmask
        |-> !activity_line9_request && !activity_line9_service;
  endproperty
  a_unmask: assert property (p_unmask) else $error("line 9 leaked to monitor");

  property p_pulldown;
    @(posedge clk_sys) disable iff (rst)
      pulldown_on |-> $past(test_en.pulldown_enable)
                      && ($past(cpu_power_down) || $past(full_power_down));
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown without cause");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
      !test_en.level_irq_enable |=> !irq_level_mode;
  endproperty
  a_level: assert property (p_level) else $error("level mode while disabled");

  property p_no_01;
    @(posedge clk_sys) disable iff (rst)
      buffer_strength != 2'h1;
  endproperty
  a_no_01: assert property (p_no_01) else $error("invalid strength code");

  property p_cal_sticky;
    @(posedge clk_sys) disable iff (rst)
      cal_done |=> cal_done;
  endproperty
  a_cal_sticky: assert property (p_cal_sticky) else $error("calibration flag fell");

endmodule

/* File: tb/diagnostic_test_registers_bench.sv */
`timescale 1ns/1ps
`include "dtr_map.svh"

module diagnostic_test_registers_bench;
  import dtr_pkg::*;

  // ==========================================================
  // Stimulus and observation signals
  logic        clk_sys;
  logic        rst;
  dtr_io_s     io_req;
  logic [15:0] io_rdata;
  logic [63:0] test_output_select_sources;
  logic        refresh_cycle;
  logic        delay_too_short;
  logic [1:0]  ems_selftest_in;
  logic [5:0]  selftest_in;
  logic        l9_req;
  logic        l9_srv;
  logic        cpu_pd;
  logic        full_pd;
  logic        el_sel;
  logic        spk_en;
  logic        test_output_select_oe;
  logic        act_req;
  logic        act_srv;
  logic        pd_on;
  logic        fa_dis;
  logic        lvl_mode;
  logic [5:0]  fact_en;
  logic [1:0]  buf_str;
  logic [15:0] rd_val;
  logic [15:0] rd_prev;
  int          miscompares;
  int          num_checks;
  int          cycles;

  dtr_regs dut_u (
    .clk_sys                   (clk_sys),
    .rst                       (rst),
    .io_req                    (io_req),
    .io_rdata                  (io_rdata),
    .test_output_select_sources              (test_output_select_sources),
    .refresh_cycle             (refresh_cycle),
    .delay_too_short           (delay_too_short),
    .ems_selftest_in           (ems_selftest_in),
    .selftest_in               (selftest_in),
    .line9_request_flag        (l9_req),
    .line9_service_flag        (l9_srv),
    .cpu_power_down            (cpu_pd),
    .full_power_down           (full_pd),
    .irq_edge_level_sel        (el_sel),
    .speaker_enable            (spk_en),
    .test_output_select_output_enable        (test_output_select_oe),
    .activity_line9_request    (act_req),
    .activity_line9_service    (act_srv),
    .pulldown_on               (pd_on),
    .first_access_page_disable (fa_dis),
    .irq_level_mode            (lvl_mode),
    .factory_test_enables      (fact_en),
    .buffer_strength           (buf_str)
  );

  // ==========================================================
  // Clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard; the whole sequence needs well under this
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk, input string msg);
    num_checks = num_checks + 1;
    if ((got & msk) !== (exp & msk)) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Write held for exactly one sampling edge
  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    io_req.addr  = a;
    io_req.wdata = d;
    io_req.wr    = 1'b1;
    @(negedge clk_sys);
    io_req.wr    = 1'b0;
  endtask

  // Read data is registered, so look one full cycle after the request is dropped
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    io_req.addr = a;
    io_req.rd   = 1'b1;
    @(negedge clk_sys);
    io_req.rd   = 1'b0;
    @(negedge clk_sys);
    d = io_rdata;
  endtask

  // One refresh pulse, then time for count and strength to settle
  task automatic refresh_pulse();
    @(negedge clk_sys);
    refresh_cycle = 1'b1;
    @(negedge clk_sys);
    refresh_cycle = 1'b0;
    cyc(4);
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({14'h0, spk_en, test_output_select_oe}, 16'h0002, 16'hFFFF, "speaker after reset");
    chk({14'h0, buf_str}, 16'h0003, 16'hFFFF, "strength after reset");
    bus_rd(16'hA072, rd_val);
    chk(rd_val, 16'h0000, 16'h00C0, "lock and freeze reset");
    bus_rd(16'hA872, rd_val);
    chk(rd_val, {`DTR_SEC_REV, 2'b10, 10'h000}, 16'hFFFF, "test enable reset");
    bus_rd(16'hDC72, rd_val);
    chk(rd_val, 16'h0000, 16'h8000, "calibration not done");
    bus_rd(16'h1234, rd_val);
    chk(rd_val, 16'h0000, 16'hFFFF, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_tune();
    refresh_pulse();
    bus_rd(16'hDC72, rd_val);
    chk(rd_val, 16'h50EA, 16'hFFFF, "step up one");
    chk({14'h0, buf_str}, 16'h0002, 16'hFFFF, "strength follows count");
    bus_wr(16'hA072, 16'h0005);
    bus_rd(16'hA072, rd_val);
    chk(rd_val, 16'h0021, 16'h00FF, "load ignored unfrozen");
    delay_too_short = 1'b0;
    cyc(6);
    refresh_pulse();
    bus_rd(16'hDC72, rd_val);
    chk(rd_val, 16'hD000, 16'hFF80, "step down, calibrated");
    $display("test tune done");
  endtask

  task automatic t_freeze();
    bus_wr(16'hA072, 16'h0040);
    refresh_pulse();
    bus_rd(16'hA072, rd_val);
    chk(rd_val, 16'h0060, 16'hFFFF, "frozen count holds");
    bus_wr(16'hA072, 16'h0055);
    cyc(3);
    bus_rd(16'hDC72, rd_val);
    chk(rd_val, 16'h8A80, 16'hFF80, "loaded 15h low strength");
    chk({14'h0, buf_str}, 16'h0000, 16'hFFFF, "buffer low strength");
    bus_wr(16'hA072, 16'h00F2);
    cyc(3);
    chk({14'h0, buf_str}, 16'h0000, 16'hFFFF, "locked strength holds");
    bus_wr(16'hA072, 16'h0073);
    cyc(3);
    chk({14'h0, buf_str}, 16'h0003, 16'hFFFF, "unlocked full strength");
    bus_rd(16'hDC72, rd_prev);
    chk(rd_prev, 16'hE000, 16'hE000, "status full strength");
    bus_wr(16'hDC72, 16'h0000);
    bus_rd(16'hDC72, rd_val);
    chk(rd_val, rd_prev, 16'hFFBF, "status write ignored");
    chk(rd_val, {10'h0, 6'h2A}, 16'h003F, "selftest nodes");
    bus_wr(16'hA072, 16'h0033);
    refresh_pulse();
    bus_rd(16'hA072, rd_val);
    chk(rd_val, 16'h0032, 16'hFFFF, "tuning resumes");
    $display("test freeze done");
  endtask

  task automatic t_test_output_select();
    bus_wr(16'h9872, 16'h0001);
    cyc(2);
    chk({14'h0, spk_en, test_output_select_oe}, 16'h0000, 16'hFFFF, "speaker silenced");
    bus_wr(16'h9872, 16'h0005);
    test_output_select_sources = 64'h20;
    cyc(6);
    chk({14'h0, spk_en, test_output_select_oe}, 16'h0003, 16'hFFFF, "reserved code");
    bus_rd(16'h9872, rd_val);
    chk(rd_val, 16'h0045, 16'h007F, "selected source high");
    test_output_select_sources = 64'hFFFF_FFFF_FFFF_FFDF;
    cyc(6);
    bus_rd(16'h9872, rd_val);
    chk(rd_val, 16'h0005, 16'h007F, "selected source low");
    bus_wr(16'h9872, 16'h0000);
    cyc(2);
    chk({14'h0, spk_en, test_output_select_oe}, 16'h0002, 16'hFFFF, "speaker normal");
    $display("test test_output_select done");
  endtask

  task automatic t_enables();
    l9_req = 1'b1;
    l9_srv = 1'b1;
    el_sel = 1'b1;
    bus_wr(16'hA872, 16'hFFFF);
    cyc(2);
    chk({5'h0, act_req, act_srv, pd_on, fa_dis, lvl_mode, fact_en}, 16'h06FF, 16'hFFFF, "enables set");
    cpu_pd = 1'b1;
    cyc(2);
    chk({15'h0, pd_on}, 16'h0001, 16'hFFFF, "pulldown in power down");
    bus_rd(16'hA872, rd_val);
    chk(rd_val, {`DTR_SEC_REV, 2'b10, 10'h3FF}, 16'hFFFF, "top bits read-only");
    ems_selftest_in = 2'b01;
    bus_wr(16'hA872, 16'h0000);
    cyc(4);
    chk({5'h0, act_req, act_srv, pd_on, fa_dis, lvl_mode, fact_en}, 16'h0000, 16'hFFFF, "enables clear");
    bus_rd(16'hA872, rd_val);
    chk(rd_val, {`DTR_SEC_REV, 2'b01, 10'h000}, 16'hFFFF, "selftest flags live");
    $display("test enables done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    miscompares     = 0;
    num_checks      = 0;
    cycles          = 0;
    rst             = 1'b1;
    io_req          = '0;
    test_output_select_sources    = 64'h0;
    refresh_cycle   = 1'b0;
    delay_too_short = 1'b1;
    ems_selftest_in = 2'b10;
    selftest_in     = 6'h2A;
    l9_req          = 1'b0;
    l9_srv          = 1'b0;
    cpu_pd          = 1'b0;
    full_pd         = 1'b0;
    el_sel          = 1'b0;
    cyc(4);
    rst = 1'b0;
    cyc(2);
    t_reset();
    t_tune();
    t_freeze();
    t_test_output_select();
    t_enables();
    give_verdict();
  end

endmodule
